/* inc/dcs_pkg.sv */
/*
  Package for the disc controller status and address block: instruction codes,
  device flag functions, command codes, field positions and timing counts.
  Assumes a single 25 MHz controller clock.
*/
package dcs_pkg;

  // ------------------------------------------------------------
  // instruction selectors on the programmed I/O port
  // ------------------------------------------------------------
  localparam logic [2:0] INSTR_NONE = 3'h0;
  localparam logic [2:0] INSTR_WRITE_A = 3'h1;
  localparam logic [2:0] INSTR_WRITE_B = 3'h2;
  localparam logic [2:0] INSTR_WRITE_C = 3'h3;
  localparam logic [2:0] INSTR_READ_A = 3'h4;
  localparam logic [2:0] INSTR_READ_B = 3'h5;
  localparam logic [2:0] INSTR_READ_C = 3'h6;

  // device flag functions
  localparam logic [1:0] FN_NONE = 2'h0;
  localparam logic [1:0] FN_START = 2'h1;
  localparam logic [1:0] FN_CLEAR = 2'h2;
  localparam logic [1:0] FN_PULSE = 2'h3;

  // command codes held in write_output_a bits 5-8
  localparam logic [3:0] CMD_READ = 4'h0;
  localparam logic [3:0] CMD_SEEK = 4'h2;
  localparam logic [3:0] CMD_ALT1 = 4'h9;
  localparam logic [3:0] CMD_ALT2 = 4'ha;

  // normal and alternate instruction modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ALT1 = 2'h1;
  localparam logic [1:0] MODE_ALT2 = 2'h2;

  // ------------------------------------------------------------
  // field positions, bit 0 is the word's most significant bit
  // ------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int BIT0 = 15;
  localparam int CMD_MSB = 10;
  localparam int CMD_LSB = 7;
  localparam int DRV_MSB = 6;
  localparam int DRV_LSB = 5;
  localparam int F5_MSB = 4;
  localparam int F6_MSB = 14;
  localparam int F6_LSB = 10;
  localparam int F11_MSB = 9;
  localparam int F11_LSB = 5;
  localparam int ADDR_MSB = 14;
  localparam int NDRV = 4;
  localparam int TR_FLAGS = 9;
  localparam int DFLT_W = 7;
  localparam int FIFO_ERR = 8;
  localparam int TOUT_ERR = 7;

  localparam logic [4:0] SECTOR_LAST = 5'h17;
  localparam logic [4:0] ZERO5 = 5'h00;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int RW_TIMEOUT_MS = 1000;
  localparam int RW_TIMEOUT_CYC = (CLK_HZ / 1000) * RW_TIMEOUT_MS;

endpackage : dcs_pkg

/* design/dcs_status_bank.sv */
/*
  Readback and address-load register bank of a four-drive disc controller.
  Assumes the host presents one instruction per cycle on instr_i with data and
  a flag function; the drive adapter and transfer engine report events as
  one-cycle pulses and drive state as levels, all synchronous to clk_i.
*/
`timescale 1ns/10ps

module dcs_status_bank #(
  parameter int TIMEOUT_CYC = dcs_pkg::RW_TIMEOUT_CYC,
  parameter logic BURST_CHAN = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] instr_i,
  input wire logic [1:0] func_i,
  input wire logic [dcs_pkg::WORD_W-1:0] wdata_i,
  input wire logic io_reset_instr_i,
  input wire logic cmd_sent_i,
  input wire logic cmd_chan_busy_i,
  input wire logic rw_end_i,
  input wire logic sector_step_i,
  input wire logic word_step_i,
  input wire logic [dcs_pkg::NDRV-1:0] drv_attn_i,
  input wire logic [1:0] rw_drive_i,
  input wire logic [dcs_pkg::NDRV*6-1:0] drv_cond_i,
  input wire logic [dcs_pkg::NDRV*dcs_pkg::DFLT_W-1:0] drv_fault_i,
  input wire logic [6:0] err_evt_i,
  input wire logic fifo_err_i,
  output logic [dcs_pkg::WORD_W-1:0] rdata_o,
  output logic busy_o,
  output logic done_o,
  output logic rw_launch_o,
  output logic pos_launch_o,
  output logic [3:0] cmd_o,
  output logic [1:0] drive_o,
  output logic [1:0] mode_o,
  output logic attn_en_o
);
  import dcs_pkg::*;

  // a count of one would flag a timeout at the edge the launch pulse is seen, and zero would never time out
  if (TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("timeout count too small");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [WORD_W-1:0] rdata;
    logic busy;
    logic done;
    logic rw_launch;
    logic pos_launch;
    logic [3:0] cmd;
    logic [1:0] drive;
    logic [1:0] mode;
    logic attn_en;
    logic map_en;
    logic [4:0] surface;
    logic [4:0] sector;
    logic [4:0] neg_count;
    logic [14:0] addr;
    logic [4:0] upper_addr;
    logic pending;
    logic [NDRV-1:0] attn;
    logic [TR_FLAGS-1:0] errs;
    logic [31:0] tcount;
  } dcs_state_type;

  dcs_state_type st_r;
  dcs_state_type st_nxt;
  logic [WORD_W-1:0] drv_word;
  logic [WORD_W-1:0] xfer_word;
  logic [DFLT_W-1:0] sel_fault;
  logic [DFLT_W-1:0] rw_fault;
  logic [5:0] sel_cond;
  logic rd_instr;
  logic [NDRV-1:0] attn_rev;
  logic start_fn;
  logic pulse_fn;

  // drive status of the command-selected drive; invalid bit from channel state
  always_comb begin
    sel_cond = drv_cond_i[st_r.drive*6 +: 6];
    sel_fault = drv_fault_i[st_r.drive*DFLT_W +: DFLT_W];
    rw_fault = drv_fault_i[rw_drive_i*DFLT_W +: DFLT_W];
    drv_word = {cmd_chan_busy_i, sel_cond, 1'b0, sel_fault, |sel_fault};
    // drive 0 reports in the leftmost attention bit, so the vector is turned round
    for (int d = 0; d < NDRV; d++) begin
      attn_rev[NDRV-1-d] = st_r.attn[d];
    end
    // error flags, then timeout, then data late, then the summary fault bit
    xfer_word = {st_r.pending, st_r.done, attn_rev, st_r.errs[TOUT_ERR-1:0], st_r.errs[TOUT_ERR],
                 st_r.errs[FIFO_ERR], (|st_r.errs) | (|rw_fault)};
    rd_instr = (instr_i == INSTR_READ_A) || (instr_i == INSTR_READ_B) || (instr_i == INSTR_READ_C);
    // a flag function only counts when it rides on a real instruction
    start_fn = (instr_i != INSTR_NONE) && (func_i == FN_START);
    pulse_fn = (instr_i != INSTR_NONE) && (func_i == FN_PULSE);
  end

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  // events are applied after the clears so that a set in the clearing cycle wins; only an io reset overrides them
  always_comb begin
    st_nxt = st_r;
    st_nxt.rw_launch = 1'b0;
    st_nxt.pos_launch = 1'b0;
    // readback selection, reading clears nothing
    case (instr_i)
      INSTR_READ_C: begin
        st_nxt.rdata = {st_r.map_en, st_r.surface, st_r.sector, st_r.neg_count};
      end
      INSTR_READ_A: begin
        if (st_r.mode == MODE_ALT1) begin
          st_nxt.rdata = {st_r.upper_addr[0], st_r.addr};
        end else begin
          st_nxt.rdata = xfer_word;
        end
      end
      INSTR_READ_B: begin
        if (st_r.mode == MODE_ALT1) begin
          st_nxt.rdata = {BURST_CHAN, 10'h000, st_r.upper_addr};
        end else begin
          st_nxt.rdata = drv_word;
        end
      end
      INSTR_WRITE_A: begin
        if (wdata_i[BIT0]) begin
          st_nxt.done = 1'b0;
          st_nxt.errs[TOUT_ERR-1:0] = '0;
          st_nxt.errs[FIFO_ERR] = 1'b0;
        end
        // command bits 1-4 clear drives 0-3, bit 1 sitting just below bit 0
        for (int d = 0; d < NDRV; d++) begin
          if (wdata_i[BIT0-1-d]) begin
            st_nxt.attn[d] = 1'b0;
          end
        end
        st_nxt.cmd = wdata_i[CMD_MSB:CMD_LSB];
        st_nxt.drive = wdata_i[DRV_MSB:DRV_LSB];
        st_nxt.upper_addr = {wdata_i[F5_MSB:1], st_r.upper_addr[0]};
        if (wdata_i[CMD_MSB:CMD_LSB] == CMD_ALT1) begin
          st_nxt.mode = MODE_ALT1;
        end else if (wdata_i[CMD_MSB:CMD_LSB] == CMD_ALT2) begin
          st_nxt.mode = MODE_ALT2;
        end else begin
          st_nxt.mode = MODE_NORMAL;
        end
      end
      INSTR_WRITE_B: begin
        st_nxt.upper_addr[0] = wdata_i[BIT0];
        st_nxt.addr = wdata_i[ADDR_MSB:0];
      end
      INSTR_WRITE_C: begin
        if (st_r.cmd != CMD_SEEK) begin
          st_nxt.map_en = wdata_i[BIT0];
          st_nxt.surface = wdata_i[F6_MSB:F6_LSB];
          st_nxt.sector = wdata_i[F11_MSB:F11_LSB];
          st_nxt.neg_count = wdata_i[F5_MSB:0];
        end
      end
      default: begin
      end
    endcase
    // flag function after the data transfer
    if (instr_i != INSTR_NONE) begin
      case (func_i)
        FN_START: begin
          st_nxt.busy = 1'b1;
          st_nxt.done = 1'b0;
          st_nxt.errs = '0;
          st_nxt.attn_en = 1'b0;
          st_nxt.tcount = TIMEOUT_CYC;
          st_nxt.rw_launch = 1'b1;
        end
        FN_CLEAR: begin
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b0;
          st_nxt.errs = '0;
          st_nxt.attn = '0;
          st_nxt.attn_en = 1'b1;
          st_nxt.tcount = '0;
        end
        FN_PULSE: begin
          st_nxt.pending = 1'b1;
          st_nxt.pos_launch = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // sector and count advance mid-sector; surface steps after the last sector
    if (sector_step_i) begin
      st_nxt.sector = (st_r.sector == SECTOR_LAST) ? ZERO5 : st_r.sector + 5'h01;
      st_nxt.neg_count = st_r.neg_count + 5'h01;
      if (st_r.sector == SECTOR_LAST) begin
        st_nxt.surface = st_r.surface + 5'h01;
      end
    end
    if (word_step_i) begin
      {st_nxt.upper_addr[0], st_nxt.addr} = {st_r.upper_addr[0], st_r.addr} + 16'h0001;
    end
    // timeout counts down while the count is nonzero, except in a start cycle; a clear function does not stop it
    if (st_r.tcount != 0 && !start_fn) begin
      st_nxt.tcount = st_r.tcount - 32'h1;
      if (st_r.tcount == 32'h1) begin
        st_nxt.errs[TOUT_ERR] = 1'b1;
      end
    end
    // a command stored in this very cycle still waits for its own delivery
    if (cmd_sent_i && !pulse_fn) begin
      st_nxt.pending = 1'b0;
    end
    if (rw_end_i) begin
      st_nxt.done = 1'b1;
      st_nxt.busy = 1'b0;
      st_nxt.tcount = '0;
      st_nxt.attn_en = 1'b1;
    end
    st_nxt.attn = st_nxt.attn | drv_attn_i;
    st_nxt.errs[TOUT_ERR-1:0] = st_nxt.errs[TOUT_ERR-1:0] | err_evt_i;
    st_nxt.errs[FIFO_ERR] = st_nxt.errs[FIFO_ERR] | fifo_err_i;
    // address, map and count survive so software can see where a transfer stopped
    if (io_reset_instr_i) begin
      st_nxt = '0;
      st_nxt.attn_en = 1'b1;
      st_nxt.cmd = CMD_READ;
      st_nxt.pending = 1'b1;
      st_nxt.map_en = st_r.map_en;
      st_nxt.neg_count = st_r.neg_count;
      st_nxt.addr = st_r.addr;
      st_nxt.upper_addr = st_r.upper_addr;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign busy_o = st_r.busy;
  assign done_o = st_r.done;
  assign rw_launch_o = st_r.rw_launch;
  assign pos_launch_o = st_r.pos_launch;
  assign cmd_o = st_r.cmd;
  assign drive_o = st_r.drive;
  assign mode_o = st_r.mode;
  assign attn_en_o = st_r.attn_en;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  pos_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    instr_i == INSTR_READ_C && !io_reset_instr_i |=> rdata_o == {$past(st_r.map_en), $past(st_r.surface),
      $past(st_r.sector), $past(st_r.neg_count)}) else $error("position readback wrong");
  start_flags_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    instr_i != INSTR_NONE && func_i == FN_START && !rw_end_i && !io_reset_instr_i
      |=> busy_o && !done_o && rw_launch_o && !attn_en_o ##1 !rw_launch_o) else $error("start function wrong");
  clear_flags_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    instr_i != INSTR_NONE && func_i == FN_CLEAR && !rw_end_i |=> !busy_o && !done_o) else $error("clear failed");
  addr_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    instr_i == INSTR_WRITE_B && !word_step_i && !io_reset_instr_i
      |=> {st_r.upper_addr[0], st_r.addr} == $past(wdata_i)) else $error("address load wrong");
  alt_b_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    instr_i == INSTR_READ_B && st_r.mode == MODE_ALT1 |=> rdata_o[14:5] == 10'h000) else $error("reserved not zero");
  drv_bit7_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    instr_i == INSTR_READ_B && st_r.mode == MODE_NORMAL |=> rdata_o[8] == 1'b0 &&
      rdata_o[0] == |rdata_o[7:1]) else $error("drive status word wrong");
  done_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rw_end_i && !io_reset_instr_i |=> done_o && !busy_o) else $error("done not set");
  attn_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    drv_attn_i[0] && !io_reset_instr_i |=> st_r.attn[0] ##1 (st_r.attn[0] || $past(instr_i) == INSTR_WRITE_A ||
      $past(func_i) == FN_CLEAR || $past(io_reset_instr_i))) else $error("attention lost");
  pend_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_sent_i && !io_reset_instr_i && !(instr_i != INSTR_NONE && func_i == FN_PULSE) |=> !st_r.pending)
    else $error("pending not cleared");
  // read data stands until the next read instruction replaces it or an io reset clears it
  rdata_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_instr && !io_reset_instr_i |=> $stable(rdata_o)) else $error("read data moved without a read");
  // sector wraps after the last one; the negated count climbs towards zero
  sect_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sector_step_i && !io_reset_instr_i |=> st_r.sector == (($past(st_r.sector) == SECTOR_LAST) ? ZERO5 :
      $past(st_r.sector) + 5'h01)) else $error("sector did not advance");
  count_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sector_step_i && !io_reset_instr_i |=> st_r.neg_count == $past(st_r.neg_count) + 5'h01)
    else $error("sector count did not advance");
  alt_a_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    instr_i == INSTR_READ_A && st_r.mode == MODE_ALT1 && !io_reset_instr_i
      |=> rdata_o[BIT0] == $past(st_r.upper_addr[0]) && rdata_o[ADDR_MSB:0] == $past(st_r.addr))
    else $error("address readback wrong");
  // stored drive commands and the io reset default
  pulse_pend_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pulse_fn && !io_reset_instr_i |=> st_r.pending && pos_launch_o) else $error("pulse did not store command");
  io_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    io_reset_instr_i |=> st_r.pending && !busy_o && !done_o && mode_o == MODE_NORMAL && attn_en_o)
    else $error("io reset state wrong");
  // event flags must land in their own place of the transfer word
  attn_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    drv_attn_i[0] && !io_reset_instr_i |=> xfer_word[WORD_W-3]) else $error("drive 0 attention not shown");
  tout_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_r.tcount == 32'h1 && !start_fn && !io_reset_instr_i |=> xfer_word[2] && xfer_word[0])
    else $error("timeout not flagged");
  fifo_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fifo_err_i && !io_reset_instr_i |=> xfer_word[1] && xfer_word[0]) else $error("data late not flagged");
  mode_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    instr_i == INSTR_WRITE_A && wdata_i[CMD_MSB:CMD_LSB] == CMD_ALT1 && !io_reset_instr_i
      |=> mode_o == MODE_ALT1) else $error("alternate mode 1 not entered");
  // command load clears, an event in the same cycle still wins
  done_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    instr_i == INSTR_WRITE_A && wdata_i[BIT0] && !rw_end_i |=> !done_o) else $error("done not cleared");
  attn_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    instr_i == INSTR_WRITE_A && wdata_i[BIT0-1] && !drv_attn_i[0] |=> !st_r.attn[0])
    else $error("drive 0 attention not cleared");

endmodule : dcs_status_bank

/* testbench/dcs_adapter_model.sv */
/*
  Drive adapter stand-in: answers read/write and position launches with
  sector, word, end and command-sent pulses. Assumes one clock, clk_i.
*/
`timescale 1ns/10ps
module dcs_adapter_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rw_launch_i,
  input wire logic pos_launch_i,
  input wire logic slow_i,
  output logic cmd_sent_o,
  output logic rw_end_o,
  output logic step_o
);
  // ------------------------------------------------------------
  // launch delay counters
  // ------------------------------------------------------------
  logic [5:0] rw_cnt_r;
  logic [3:0] pos_cnt_r;

  // slow answers outlast the shortened read/write timeout on purpose
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rw_cnt_r <= 6'h00;
      pos_cnt_r <= 4'h0;
    end else begin
      if (rw_launch_i) begin
        rw_cnt_r <= slow_i ? 6'h28 : 6'h04;
      end else if (rw_cnt_r != 6'h00) begin
        rw_cnt_r <= rw_cnt_r - 6'h01;
      end
      if (pos_launch_i) begin
        pos_cnt_r <= 4'hc;
      end else if (pos_cnt_r != 4'h0) begin
        pos_cnt_r <= pos_cnt_r - 4'h1;
      end
    end
  end

  // one sector and one word move before the end pulse
  assign step_o = (rw_cnt_r == 6'h02);
  assign rw_end_o = (rw_cnt_r == 6'h01);
  assign cmd_sent_o = (pos_cnt_r == 4'h1);
endmodule : dcs_adapter_model

/* testbench/tb.sv */
/*
  Self-checking bench for the disc status bank with an adapter stand-in.
  Assumes read data stands from the edge after the read instruction.
*/
`timescale 1ns/10ps
module tb;
  import dcs_pkg::*;
  localparam int TOUT = 20;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] instr_i = INSTR_NONE;
  logic [1:0] func_i = FN_NONE;
  logic [15:0] wdata_i = 16'h0000;
  logic io_reset_instr_i = 1'b0;
  logic cmd_chan_busy_i = 1'b0;
  logic [3:0] drv_attn_i = 4'h0;
  logic [1:0] rw_drive_i = 2'h0;
  logic [23:0] drv_cond_i = 24'h000000;
  logic [27:0] drv_fault_i = 28'h0000000;
  logic [6:0] err_evt_i = 7'h00;
  logic fifo_err_i = 1'b0;
  logic slow = 1'b0;
  logic cmd_sent_i, rw_end_i, step, busy_o, done_o, rw_launch_o, pos_launch_o, attn_en_o;
  logic [15:0] rdata_o;
  logic [3:0] cmd_o;
  logic [1:0] drive_o, mode_o;
  int mismatches = 0;
  int checked = 0;
  logic rd_prev = 1'b0;
  logic [31:0] cur;
  logic [31:0] expq[$];

  // ------------------------------------------------------------
  // bank, adapter stand-in and clock
  // ------------------------------------------------------------
  dcs_status_bank #(.TIMEOUT_CYC(TOUT), .BURST_CHAN(1'b1)) dut (.clk_i, .rst_n_i, .instr_i, .func_i, .wdata_i,
    .io_reset_instr_i, .cmd_sent_i, .cmd_chan_busy_i, .rw_end_i, .sector_step_i(step), .word_step_i(step),
    .drv_attn_i, .rw_drive_i, .drv_cond_i, .drv_fault_i, .err_evt_i, .fifo_err_i, .rdata_o, .busy_o,
    .done_o, .rw_launch_o, .pos_launch_o, .cmd_o, .drive_o, .mode_o, .attn_en_o);
  dcs_adapter_model partner (.clk_i, .rst_n_i, .rw_launch_i(rw_launch_o), .pos_launch_i(pos_launch_o),
    .slow_i(slow), .cmd_sent_o(cmd_sent_i), .rw_end_o(rw_end_i), .step_o(step));
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // masked compare: unknown bits under the mask never match
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] msk);
    checked++;
    if (((got ^ exp) & msk) !== 16'h0000) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h mask %h", $time, got, exp, msk);
    end
  endtask : chk

  // one instruction, then idle; ends at a negedge so outputs have settled
  task automatic op(input logic [2:0] i, input logic [1:0] f, input logic [15:0] d);
    @(posedge clk_i);
    instr_i <= i;
    func_i <= f;
    wdata_i <= d;
    @(posedge clk_i);
    instr_i <= INSTR_NONE;
    func_i <= FN_NONE;
    @(negedge clk_i);
  endtask : op

  task automatic rd(input logic [2:0] i, input logic [15:0] e, input logic [15:0] m);
    expq.push_back({e, m});
    op(i, FN_NONE, 16'h0000);
  endtask : rd

  task automatic evt(input logic [6:0] e, input logic [3:0] a);
    @(posedge clk_i);
    err_evt_i <= e;
    fifo_err_i <= 1'b1;
    drv_attn_i <= a;
    @(posedge clk_i);
    err_evt_i <= 7'h00;
    fifo_err_i <= 1'b0;
    drv_attn_i <= 4'h0;
  endtask : evt

  task automatic wait_done();
    int n;
    n = 0;
    while (done_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk({14'h0, busy_o, done_o}, 16'h0001, 16'h0003);
  endtask : wait_done

  // results are taken off the queue half a cycle after they are launched
  always @(posedge clk_i) begin
    rd_prev <= (instr_i >= INSTR_READ_A);
  end
  always @(negedge clk_i) begin
    if (rd_prev && expq.size() > 0) begin
      cur = expq.pop_front();
      chk(rdata_o, cur[31:16], cur[15:0]);
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] pw, ab;
    logic [6:0] ev, f;
    logic [5:0] c;
    logic [4:0] up;
    void'($urandom(60414));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(INSTR_READ_C, 16'h0000, 16'hffff);
    rd(INSTR_READ_A, 16'h0000, 16'h7fff);
    pw = 16'($urandom);
    pw[9:5] = 5'($urandom_range(22, 0));
    ab = 16'($urandom) & 16'hfffe;
    up = 5'($urandom);
    op(INSTR_WRITE_C, FN_NONE, pw);
    rd(INSTR_READ_C, pw, 16'hffff);
    op(INSTR_WRITE_B, FN_START, ab);
    chk({12'h0, busy_o, done_o, rw_launch_o, attn_en_o}, 16'h000a, 16'h000f);
    wait_done();
    rd(INSTR_READ_C, {pw[15:10], pw[9:5] + 5'h01, pw[4:0] + 5'h01}, 16'hffff);
    rd(INSTR_READ_A, 16'h4000, 16'h4000);
    op(INSTR_WRITE_A, FN_NONE, {5'h00, CMD_ALT1, 2'h0, up});
    chk({14'h0, mode_o}, {14'h0, MODE_ALT1}, 16'h0003);
    rd(INSTR_READ_A, ab + 16'h0001, 16'hffff);
    rd(INSTR_READ_B, {1'b1, 10'h000, up[4:1], ab[15]}, 16'hffff);
    op(INSTR_WRITE_A, FN_NONE, {5'h00, CMD_ALT2, 7'h00});
    chk({14'h0, mode_o}, {14'h0, MODE_ALT2}, 16'h0003);
    op(INSTR_WRITE_A, FN_NONE, 16'h0000);
    ev = 7'($urandom) | 7'h01;
    evt(ev, 4'b0101);
    rd(INSTR_READ_A, {2'h0, 4'b1010, ev, 3'b011}, 16'h3fff);
    rd(INSTR_READ_A, {2'h0, 4'b1010, ev, 3'b011}, 16'h3fff);
    op(INSTR_WRITE_A, FN_NONE, 16'hc000);
    rd(INSTR_READ_A, 16'h0800, 16'h7fff);
    for (int d = 0; d < 4; d++) begin
      @(posedge clk_i);
      drv_cond_i <= 24'($urandom);
      drv_fault_i <= 28'($urandom);
      cmd_chan_busy_i <= 1'($urandom);
      rw_drive_i <= 2'($urandom);
      op(INSTR_WRITE_A, FN_NONE, {9'h000, 2'(d), 5'h00});
      chk({14'h0, drive_o}, 16'(d), 16'h0003);
      c = drv_cond_i[d*6+:6];
      f = drv_fault_i[d*7+:7];
      rd(INSTR_READ_B, {cmd_chan_busy_i, c, 1'b0, f, |f},
        cmd_chan_busy_i ? 16'hf900 : 16'hffff);
    end
    rd(INSTR_READ_A, {15'h0, |drv_fault_i[rw_drive_i*7+:7]}, 16'h0001);
    evt(7'h7f, 4'h0);
    slow <= 1'b1;
    op(INSTR_WRITE_B, FN_START, ab);
    repeat (TOUT + 5) @(posedge clk_i);
    rd(INSTR_READ_A, 16'h0004, 16'h03fe);
    @(posedge clk_i);
    slow <= 1'b0;
    wait_done();
    op(INSTR_WRITE_A, FN_CLEAR, {5'h00, CMD_SEEK, 7'h00});
    chk({14'h0, busy_o, done_o}, 16'h0000, 16'h0003);
    rd(INSTR_READ_A, 16'h0000, 16'h7ffe);
    op(INSTR_WRITE_C, FN_PULSE, 16'h0000);
    chk({15'h0, pos_launch_o}, 16'h0001, 16'h0001);
    rd(INSTR_READ_A, 16'h8000, 16'h8000);
    repeat (15) @(posedge clk_i);
    rd(INSTR_READ_A, 16'h0000, 16'h8000);
    @(posedge clk_i);
    io_reset_instr_i <= 1'b1;
    @(posedge clk_i);
    io_reset_instr_i <= 1'b0;
    @(negedge clk_i);
    chk({9'h0, cmd_o, mode_o, attn_en_o}, {9'h0, CMD_READ, MODE_NORMAL, 1'b1}, 16'h007f);
    rd(INSTR_READ_A, 16'h8000, 16'hc000);
    rd(INSTR_READ_C, 16'h0000, 16'h7fe0);
    conclude();
  end

  // watchdog: the sequence needs about 140 cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    conclude();
  end
endmodule : tb
